// ===== testbench/flow_through_sram_port_test.sv
// self-checking bench for the flow-through sram port
`timescale 1ns/100ps
`default_nettype none
module flow_through_sram_port_test;
  logic        clk, rst_b, sleep_request, output_enable_n, burst_mode, act, wt, pw;
  logic        test_clock, test_mode_select, test_data_in;
  logic [3:0]  base, pa, pb;
  logic [1:0]  cnt;
  logic [31:0] seed, r;
  logic [35:0] mem [16];
  int          mismatches, cmp_count;
  wire logic        clock_qualify_n, chip_select_1_n, write_enable_n, advance_or_load;
  wire logic        chip_select_2, chip_select_3_n;
  wire logic        dq_oe, parity_lines_oe, test_data_out;
  wire logic [3:0]  byte_write_select_n, address, parity_lines_out;
  wire logic [31:0] dq_out;
  wire logic [35:0] write_data;
  fsr_master u_fsr_master (.*);
  fsr_port #(.ADDR_W(4)) u_fsr_port (.*,
    .dq_in(dq_oe ? dq_out : write_data[31:0]),
    .parity_lines_in(parity_lines_oe ? parity_lines_out : write_data[35:32]));
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  function automatic logic [31:0] rnd;
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [35:0] lanes(input logic [3:0] b);
    for (int i = 0; i < 4; i++) {lanes[32+i], lanes[i*8+:8]} = {9{!b[i]}};
  endfunction
  function automatic logic [3:0] beat(input logic [3:0] a, input logic [1:0] i, input logic m);
    return m ? a ^ {2'h0, i} : {a[3:2], a[1:0] + i};
  endfunction
  task automatic chk(input string n, input logic [35:0] s, e);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // one cycle; a write's data lands on the next qualified edge
  task automatic step(input logic q, s, w, v, input logic [3:0] a, b);
    logic [63:0] d;
    d = {rnd(), rnd()};
    u_fsr_master.op(q, s, w, v, b, a, d[37:0]);
    if (!q) begin
      if (pw) mem[pa] = mem[pa] & ~lanes(pb) | d[35:0] & lanes(pb);
      if (!v) {act, wt, base, cnt} = {!s, !w, a, 2'h0};
      else cnt = cnt + 2'h1;
      {pw, pa, pb} = {act && wt, beat(base, cnt, burst_mode), b};
      if (act && !wt) chk("read data", {parity_lines_out, dq_out}, mem[pa]);
      chk("drive enable", {35'h0, dq_oe}, {35'h0, act && !wt && !output_enable_n});
    end
  endtask
  initial begin
    #100000;
    mismatches++;
    report_and_stop;
  end
  initial begin
    {rst_b, sleep_request, output_enable_n, burst_mode, test_clock, test_mode_select, test_data_in} = '0;
    {act, wt, pw, base, pa, pb, cnt, r, mismatches, cmp_count} = '0;
    seed = 32'h0000_4c50;
    for (int m = 0; m < 2; m++) begin
      rst_b = 0;
      burst_mode = m[0];
      foreach (mem[i]) mem[i] = '0;
      repeat (3) @(posedge clk);
      #1 rst_b = 1;
      repeat (3) step(0, 1, 1, 0, 4'h0, 4'h0);
      r = rnd();
      // write burst then read burst, selects and write strobe flipped on advances
      for (int i = 0; i < 8; i++) step(i == 6, i[1:0] != 0, i[2] ^ (i[1:0] != 0), i[1:0] != 0, r[3:0], 4'h0);
      for (int i = 0; i < 60; i++) begin
        r = rnd();
        output_enable_n = r[0] & r[1];
        if (i % 4 == 0) test_clock = 1;
        if (i % 4 == 2) test_clock = 0;
        if (i % 4 == 3) {test_data_in, test_mode_select} = r[21:20];
        step(r[2] & r[3] & r[4], r[5] & r[6], r[7], r[8] & r[9], r[15:12], r[19:16]);
      end
      output_enable_n = 0;
      sleep_request = 1;
      repeat (5) step(0, 1, 1, 0, 4'h0, 4'h0);
      sleep_request = 0;
      repeat (3) step(0, 1, 1, 0, 4'h0, 4'h0);
      for (int i = 0; i < 16; i++) step(0, 0, 1, 0, i[3:0], 4'hf);
    end
    report_and_stop;
  end
endmodule
bind fsr_port fsr_port_checker #(.BYTES(BYTES)) u_fsr_port_checker (.*);
`default_nettype wire

// ===== testbench/fsr_master.sv
// bus master model that drives the sram pins
`timescale 1ns/100ps
`default_nettype none
module fsr_master (
  input  wire logic   clk,
  output logic        clock_qualify_n,
  output logic        chip_select_1_n,
  output logic        chip_select_2,
  output logic        chip_select_3_n,
  output logic        write_enable_n,
  output logic        advance_or_load,
  output logic [3:0]  byte_write_select_n,
  output logic [3:0]  address,
  output logic [35:0] write_data
);
  logic act_reg, wr_reg;
  initial begin
    {clock_qualify_n, chip_select_1_n, write_enable_n, advance_or_load, byte_write_select_n, address} = '1;
    {chip_select_2, chip_select_3_n, act_reg, wr_reg, write_data} = '0;
  end
  // released data lines toggle so a stale value never passes
  // a deselect drops one of the three selects, or all of them, chosen by d[37:36]
  task automatic op(input logic q, s, w, v, input logic [3:0] b, a, input logic [37:0] d);
    {clock_qualify_n, write_enable_n, advance_or_load} = {q, w, v};
    chip_select_1_n = s && (d[36] == d[37]);
    chip_select_2 = !(s && d[36]);
    chip_select_3_n = s && d[37];
    {byte_write_select_n, address} = {b, a};
    write_data = act_reg && wr_reg ? d[35:0] : ~write_data;
    @(posedge clk);
    if (!q && !v) {act_reg, wr_reg} = {!s, !w};
    #1;
  endtask
endmodule
`default_nettype wire

// ===== testbench/fsr_port_checker.sv
// assertions on the pins of the flow-through sram port
`timescale 1ns/100ps
`default_nettype none
module fsr_port_checker #(parameter int unsigned BYTES = 4) (
  input wire logic               clk,
  input wire logic               rst_b,
  input wire logic               clock_qualify_n,
  input wire logic               sleep_request,
  input wire logic               chip_select_1_n,
  input wire logic               chip_select_2,
  input wire logic               chip_select_3_n,
  input wire logic               write_enable_n,
  input wire logic               advance_or_load,
  input wire logic               output_enable_n,
  input wire logic [BYTES*8-1:0] dq_out,
  input wire logic               dq_oe,
  input wire logic               parity_lines_oe,
  input wire logic               test_clock,
  input wire logic               test_data_in,
  input wire logic               test_data_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire logic sel  = !chip_select_1_n && chip_select_2 && !chip_select_3_n;
  wire logic load = !clock_qualify_n && !advance_or_load && !sleep_request && sel;
  // read taken, then output enable low with no sleep
  sequence rd_taken;
    load && write_enable_n ##1 !output_enable_n && !sleep_request;
  endsequence
  masked_hold_a: assert property (clock_qualify_n |=> $stable(dq_out))
    else $error("read data moved on masked edge");
  oe_gate_a: assert property (output_enable_n |-> !dq_oe)
    else $error("driving with output enable high");
  parity_oe_a: assert property (parity_lines_oe == dq_oe)
    else $error("parity drive differs from data");
  write_float_a: assert property (load && !write_enable_n |=> !dq_oe)
    else $error("driving in write data phase");
  desel_float_a: assert property (!clock_qualify_n && !advance_or_load && !sel |=> !dq_oe)
    else $error("driving after deselect");
  read_drive_a: assert property (rd_taken |-> dq_oe)
    else $error("read data not driven");
  sleep_float_a: assert property (sleep_request [*3] |-> !dq_oe)
    else $error("driving while asleep");
  tap_shift_a: assert property ($fell(test_clock) |=> test_data_out == $past(test_data_in))
    else $error("test output not shifted on fall");
endmodule
`default_nettype wire

// ===== verilog/fsr_pkg.sv
// package: constants and types for the flow-through sram port
`default_nettype none

package fsr_pkg;

  // ----------------------------------------------------------------
  // sizes and reset values
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W_DEF = 18;
  localparam int unsigned BYTES_DEF  = 4;
  localparam int unsigned LANE_W     = 8;
  localparam logic [1:0]  CNT_RST    = 2'h0;
  localparam logic        BURST_LIN_RST = 1'b0;

  // ----------------------------------------------------------------
  // access type held for the whole burst
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FSR_IDLE  = 2'b00,
    FSR_READ  = 2'b01,
    FSR_WRITE = 2'b10
  } fsr_op_t;

endpackage

`default_nettype wire

// ===== verilog/fsr_port.sv
// module: flow-through burst sram port with tap edge logic
`timescale 1ns/100ps
`default_nettype none

module fsr_port #(
  parameter int unsigned ADDR_W = fsr_pkg::ADDR_W_DEF,
  parameter int unsigned BYTES  = fsr_pkg::BYTES_DEF
) (
  input  wire logic                              clk,
  input  wire logic                              rst_b,
  input  wire logic                              clock_qualify_n,
  input  wire logic                              sleep_request,
  input  wire logic                              chip_select_1_n,
  input  wire logic                              chip_select_2,
  input  wire logic                              chip_select_3_n,
  input  wire logic                              write_enable_n,
  input  wire logic                              advance_or_load,
  input  wire logic [BYTES-1:0]                  byte_write_select_n,
  input  wire logic [ADDR_W-1:0]                 address,
  input  wire logic                              output_enable_n,
  input  wire logic                              burst_mode,
  input  wire logic [BYTES*fsr_pkg::LANE_W-1:0]  dq_in,
  output logic      [BYTES*fsr_pkg::LANE_W-1:0]  dq_out,
  output logic                                   dq_oe,
  input  wire logic [BYTES-1:0]                  parity_lines_in,
  output logic      [BYTES-1:0]                  parity_lines_out,
  output logic                                   parity_lines_oe,
  input  wire logic                              test_clock,
  input  wire logic                              test_mode_select,
  input  wire logic                              test_data_in,
  output logic                                   test_data_out
);

  localparam int unsigned DATA_W = BYTES * fsr_pkg::LANE_W;
  localparam int unsigned WORD_W = DATA_W + BYTES;
  localparam int unsigned DEPTH  = 1 << ADDR_W;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  // memory lives in the state flops: cheap at sim depth, huge at the default
  typedef struct packed {
    logic [DEPTH-1:0][WORD_W-1:0] mem;
    fsr_pkg::fsr_op_t             op;
    logic [ADDR_W-1:0]            base;
    logic [1:0]                   cnt;
    logic                         wr_pend;
    logic [ADDR_W-1:0]            wr_addr;
    logic [BYTES-1:0]             wr_bw_n;
    logic [WORD_W-1:0]            rd_data;
    logic                         drive;
    logic                         burst_lin;
    logic                         mode_caught;
    logic [1:0]                   slp_sync;
    logic                         tck;
    logic                         tdi_cap;
    logic                         tms_cap;
    logic                         tdo;
  } fsr_state_t;

  fsr_state_t  state_reg;
  fsr_state_t  state_next;
  logic [1:0]  rst_sync_reg;
  logic        rst_int_b;

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  // entry is immediate, exit waits two edges so no flop leaves reset early
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  assign rst_int_b = rst_sync_reg[1];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] wr_word;
  logic [ADDR_W-1:0] acc_addr;
  logic [1:0]        nxt_cnt;
  logic [1:0]        beat_lsb;
  logic              selected;
  logic              asleep;
  logic              do_access;
  logic              tck_rise;
  logic              tck_fall;
  fsr_pkg::fsr_op_t  acc_op;

  always_comb begin
    state_next = state_reg;
    selected   = !chip_select_1_n && chip_select_2 && !chip_select_3_n;
    asleep     = state_reg.slp_sync[1];
    do_access  = 1'b0;
    acc_op     = state_reg.op;
    nxt_cnt    = state_reg.cnt;
    acc_addr   = state_reg.base;
    beat_lsb   = state_reg.base[1:0];
    tck_rise   = test_clock && !state_reg.tck;
    tck_fall   = !test_clock && state_reg.tck;

    // pending write merged with the lanes its selects enable
    wr_word = state_reg.mem[state_reg.wr_addr];
    for (int i = 0; i < BYTES; i++) begin
      if (!state_reg.wr_bw_n[i]) begin
        wr_word[i*fsr_pkg::LANE_W +: fsr_pkg::LANE_W] = dq_in[i*fsr_pkg::LANE_W +: fsr_pkg::LANE_W];
        wr_word[DATA_W+i] = parity_lines_in[i];
      end
    end

    // strap caught once after reset release
    // a floating strap cannot be seen here, so the pin must be driven
    if (!state_reg.mode_caught) begin
      state_next.burst_lin   = !burst_mode;
      state_next.mode_caught = 1'b1;
    end

    // sleep is asynchronous, so it is brought in through two flops
    state_next.slp_sync = {state_reg.slp_sync[0], sleep_request};

    // masked edges leave everything below down to the test port untouched
    if (!clock_qualify_n) begin
      // a data edge still lands if sleep starts on it
      if (state_reg.wr_pend) begin
        state_next.mem[state_reg.wr_addr] = wr_word;
        state_next.wr_pend = 1'b0;
      end
      if (asleep) begin
        // contents kept; nothing new starts while asleep
        state_next.op    = fsr_pkg::FSR_IDLE;
        state_next.drive = 1'b0;
      end else if (advance_or_load) begin
        // selects and write strobe ignored while advancing
        if (state_reg.op != fsr_pkg::FSR_IDLE) begin
          nxt_cnt        = state_reg.cnt + 2'h1;
          state_next.cnt = nxt_cnt;
          do_access      = 1'b1;
        end else begin
          // advancing with no burst open leaves the port idle
          state_next.drive = 1'b0;
        end
      end else if (selected) begin
        acc_op          = write_enable_n ? fsr_pkg::FSR_READ : fsr_pkg::FSR_WRITE;
        state_next.op   = acc_op;
        state_next.base = address;
        nxt_cnt         = fsr_pkg::CNT_RST;
        state_next.cnt  = nxt_cnt;
        do_access       = 1'b1;
      end else begin
        state_next.op    = fsr_pkg::FSR_IDLE;
        state_next.drive = 1'b0;
      end

      if (do_access) begin
        acc_addr = state_next.base;
        if (state_reg.burst_lin) begin
          beat_lsb = state_next.base[1:0] + nxt_cnt;
        end else begin
          beat_lsb = state_next.base[1:0] ^ nxt_cnt;
        end
        acc_addr[1:0] = beat_lsb;
        if (acc_op == fsr_pkg::FSR_READ) begin
          // forward a write that completes on this same edge
          if (state_reg.wr_pend && state_reg.wr_addr == acc_addr) begin
            state_next.rd_data = wr_word;
          end else begin
            state_next.rd_data = state_reg.mem[acc_addr];
          end
          state_next.drive = 1'b1;
        end else begin
          state_next.wr_pend = 1'b1;
          state_next.wr_addr = acc_addr;
          state_next.wr_bw_n = byte_write_select_n;
          state_next.drive   = 1'b0;
        end
      end
    end

    // test port: test clock sampled as an ordinary input
    state_next.tck = test_clock;
    if (tck_rise) begin
      state_next.tdi_cap = test_data_in;
      state_next.tms_cap = test_mode_select;
    end
    if (tck_fall) begin
      // single-bit bypass path only
      state_next.tdo = state_reg.tdi_cap;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_int_b) begin
    if (!rst_int_b) begin
      state_reg             <= '0;
      state_reg.op          <= fsr_pkg::FSR_IDLE;
      state_reg.cnt         <= fsr_pkg::CNT_RST;
      state_reg.burst_lin   <= fsr_pkg::BURST_LIN_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // enable stays combinational: the pin's output enable is asynchronous
  logic drive_ok;

  assign drive_ok         = state_reg.drive && !output_enable_n && !state_reg.slp_sync[1];
  assign dq_out           = state_reg.rd_data[DATA_W-1:0];
  assign parity_lines_out = state_reg.rd_data[WORD_W-1:DATA_W];
  assign dq_oe            = drive_ok;
  assign parity_lines_oe  = drive_ok;
  assign test_data_out    = state_reg.tdo;

endmodule

`default_nettype wire
